// ---- verilog/ckc_clock_ctrl.sv ----
/*
 * Clock generator and master clock control: main oscillator enable and
 * start-up counting, main clock frequency measurement, two PLL control
 * channels with lock counters, master clock selection and prescaling,
 * and processor clock idle gating.
 * Assumes slow_clock and main_clock are levels synchronous to clk, and
 * src_tick carries one-cycle pulses of clock sources 1 to 3; bit 0 is unused, since the slow source comes from slow_clock.
 */
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module ckc_clock_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clock references and sources
  input wire logic slow_clock,
  input wire logic main_clock,
  input wire logic [3:0] src_tick,
  // Processor side
  input wire logic fast_int,
  input wire logic norm_int,
  input wire logic instr_done,
  // Oscillator controls
  output logic osc_enable,
  output logic osc_bypass,
  // PLL controls
  output logic [ckc_pkg::CKC_DIV_W-1:0] pll_a_div,
  output logic [ckc_pkg::CKC_MUL_W-1:0] pll_a_mul,
  output logic pll_a_run,
  output logic [ckc_pkg::CKC_DIV_W-1:0] pll_b_div,
  output logic [ckc_pkg::CKC_MUL_W-1:0] pll_b_mul,
  output logic pll_b_run,
  // Master and processor clock, interrupt
  output logic master_clock_tick,
  output logic [1:0] master_divider_select,
  output logic processor_clock_en,
  output logic irq
);
  import ckc_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic wr_pend_q;           // Write data phase due
  logic [7:0] wr_addr_q;     // Latched write offset
  logic addr_phase;          // Transfer accepted this cycle
  logic [31:0] rd_word;      // Read mux output

  // Write strobe for one offset in the data phase
  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
    wr_hit = pend && (a == off);
  endfunction

  assign addr_phase = hsel && htrans[1] && hready;

  // Latch write address phase; zero wait states so hready is always ours
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Response is always okay and never stretched
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Slow and main clock edge detection
  // ****************************************
  logic slow_q, main_q;      // Previous samples
  logic slow_rise, slow_fall, main_rise;
  logic [2:0] slow_div_q;    // Divider for the start-up counter
  logic slow8_tick;          // One pulse per eight slow periods

  always_ff @(posedge clk) begin
    if (srst) begin
      slow_q <= 1'b0;
      main_q <= 1'b0;
    end else begin
      slow_q <= slow_clock;
      main_q <= main_clock;
    end
  end

  assign slow_rise = slow_clock && !slow_q;
  assign slow_fall = !slow_clock && slow_q;
  assign main_rise = main_clock && !main_q;

  // Free-running slow/8 divider
  always_ff @(posedge clk) begin
    if (srst) begin
      slow_div_q <= 3'h0;
    end else if (slow_rise) begin
      slow_div_q <= slow_div_q + 3'h1;
    end
  end

  assign slow8_tick = slow_rise && (slow_div_q == CKC_SLOW_DIV);

  // ****************************************
  // Main oscillator
  // ****************************************
  logic [CKC_OSC_CNT_W-1:0] osc_cnt_q;   // Start-up count field, width
  logic [CKC_OSC_CNT_W-1:0] osc_left_q;  // Counter running down
  logic osc_run_q;                       // Start-up wait in progress
  logic osc_stable_flag_q;
  logic osc_wr;

  assign osc_wr = wr_hit(wr_pend_q, wr_addr_q, CKC_OFF_MAIN_OSC);

  // Control fields; enable and bypass come up clear
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_enable <= 1'b0;
      osc_bypass <= 1'b0;
      osc_cnt_q <= '0;
    end else if (osc_wr) begin
      osc_enable <= hwdata[CKC_OSC_EN_BIT];
      osc_bypass <= hwdata[CKC_OSC_BYP_BIT];
      osc_cnt_q <= hwdata[CKC_OSC_CNT_LSB +: CKC_OSC_CNT_W];
    end
  end

  // Start-up countdown; disable wins, since a dead oscillator is never stable
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_run_q <= 1'b0;
      osc_left_q <= '0;
      osc_stable_flag_q <= 1'b0;
    end else if (osc_wr && !hwdata[CKC_OSC_EN_BIT]) begin
      osc_run_q <= 1'b0;
      osc_stable_flag_q <= 1'b0;
    end else if (osc_wr) begin
      osc_run_q <= 1'b1;
      osc_left_q <= hwdata[CKC_OSC_CNT_LSB +: CKC_OSC_CNT_W];
      osc_stable_flag_q <= 1'b0;
    end else if (osc_run_q && osc_left_q == '0) begin
      osc_run_q <= 1'b0;
      osc_stable_flag_q <= 1'b1;
    end else if (osc_run_q && slow8_tick) begin
      osc_left_q <= osc_left_q - 1'b1;
    end
  end

  // ****************************************
  // Main clock frequency counter
  // ****************************************
  ckc_freq_state_t freq_q;
  logic [CKC_FREQ_W-1:0] main_freq_count_q;
  logic [4:0] fall_cnt_q;    // Slow falling edges seen in measurement
  logic freq_count_ready_q;

  // Restarted by any oscillator write so a stale figure is never shown
  always_ff @(posedge clk) begin
    if (srst || osc_wr || !osc_stable_flag_q) begin
      freq_q <= CKC_F_IDLE;
      main_freq_count_q <= '0;
      fall_cnt_q <= 5'h00;
      freq_count_ready_q <= 1'b0;
    end else begin
      case (freq_q)
        CKC_F_IDLE: begin
          freq_q <= CKC_F_WAIT;
        end
        CKC_F_WAIT: begin
          if (slow_rise) begin
            freq_q <= CKC_F_COUNT;
          end
        end
        CKC_F_COUNT: begin
          if (main_rise) begin
            main_freq_count_q <= main_freq_count_q + 1'b1;
          end
          if (slow_fall) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
            if (fall_cnt_q + 5'h01 == CKC_MEAS_PERIODS) begin
              freq_q <= CKC_F_DONE;
              freq_count_ready_q <= 1'b1;
            end
          end
        end
        CKC_F_DONE: begin
          freq_q <= CKC_F_DONE;
        end
        default: begin
          freq_q <= CKC_F_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // PLL channels
  // ****************************************
  logic [CKC_DIV_W-1:0] pll_div_q [2];
  logic [CKC_MUL_W-1:0] pll_mul_q [2];
  logic [CKC_SETTLE_W-1:0] pll_settle_q [2];
  logic [CKC_SETTLE_W-1:0] pll_left_q [2];
  logic [1:0] pll_run_q;     // Lock counter running
  logic [1:0] pll_locked_q;  // Lock flags, A then B
  logic [1:0] pll_on_q;      // Divider and multiplier both nonzero

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pll
      logic wr;              // This channel's register written
      logic [CKC_DIV_W-1:0] new_div;
      logic [CKC_MUL_W-1:0] new_mul;
      logic [CKC_SETTLE_W-1:0] new_settle;

      assign wr = wr_hit(wr_pend_q, wr_addr_q, (g == 0) ? CKC_OFF_PLL_A : CKC_OFF_PLL_B);
      assign new_div = hwdata[CKC_DIV_LSB +: CKC_DIV_W];
      assign new_mul = hwdata[CKC_MUL_LSB +: CKC_MUL_W];
      assign new_settle = hwdata[CKC_SETTLE_LSB +: CKC_SETTLE_W];

      // Fields reset to zero: divider output held low, PLL off
      always_ff @(posedge clk) begin
        if (srst) begin
          pll_div_q[g] <= '0;
          pll_mul_q[g] <= '0;
          pll_settle_q[g] <= '0;
        end else if (wr) begin
          pll_div_q[g] <= new_div;
          pll_mul_q[g] <= new_mul;
          pll_settle_q[g] <= new_settle;
        end
      end

      // Output runs only with a nonzero divider and multiplier
      always_ff @(posedge clk) begin
        if (srst) begin
          pll_on_q[g] <= 1'b0;
        end else begin
          pll_on_q[g] <= (pll_div_q[g] != '0) && (pll_mul_q[g] != '0);
        end
      end

      // Lock counter; a divider or multiplier change restarts the wait, a zero multiplier stops it
      always_ff @(posedge clk) begin
        if (srst) begin
          pll_run_q[g] <= 1'b0;
          pll_left_q[g] <= '0;
          pll_locked_q[g] <= 1'b0;
        end else if (wr && new_mul == '0) begin
          pll_run_q[g] <= 1'b0;
          pll_locked_q[g] <= 1'b0;
        end else if (wr && (new_mul != pll_mul_q[g] || new_div != pll_div_q[g])) begin
          pll_run_q[g] <= 1'b1;
          pll_left_q[g] <= new_settle;
          pll_locked_q[g] <= 1'b0;
        end else if (pll_run_q[g] && pll_left_q[g] == '0) begin
          pll_run_q[g] <= 1'b0;
          pll_locked_q[g] <= 1'b1;
        end else if (pll_run_q[g] && slow_rise) begin
          pll_left_q[g] <= pll_left_q[g] - 1'b1;
        end
      end
    end
  endgenerate

  assign pll_a_div = pll_div_q[0];
  assign pll_a_mul = pll_mul_q[0];
  assign pll_a_run = pll_on_q[0];
  assign pll_b_div = pll_div_q[1];
  assign pll_b_mul = pll_mul_q[1];
  assign pll_b_run = pll_on_q[1];

  // ****************************************
  // Master clock
  // ****************************************
  logic [1:0] css_q;         // Source select
  logic [2:0] prescaler_select_q;        // Prescaler select
  logic [5:0] prescaler_select_cnt_q;    // Prescaler counter
  logic master_clock_ready_q;
  logic mck_wr, src_pick, prescaler_select_end;

  assign mck_wr = wr_hit(wr_pend_q, wr_addr_q, CKC_OFF_MCK);

  // Selection fields; slow clock and no division at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      css_q <= CKC_CSS_SLOW;
      prescaler_select_q <= 3'h0;
      master_divider_select <= 2'h0;
    end else if (mck_wr) begin
      css_q <= hwdata[CKC_CSS_LSB +: 2];
      prescaler_select_q <= (hwdata[CKC_PRESCALER_SELECT_LSB +: 3] > CKC_PRESCALER_SELECT_MAX) ? CKC_PRESCALER_SELECT_MAX
                                                             : hwdata[CKC_PRESCALER_SELECT_LSB +: 3];
      master_divider_select <= hwdata[CKC_MASTER_DIVIDER_SELECT_LSB +: 2];
    end
  end

  // Slow clock source is the detected rising edge, the rest come as ticks
  assign src_pick = (css_q == CKC_CSS_SLOW) ? slow_rise : src_tick[css_q];
  // Counter wraps at 2^prescaler_select source ticks
  assign prescaler_select_end = (prescaler_select_cnt_q == 6'((7'h01 << prescaler_select_q) - 7'h01));

  // Power-of-two prescaler on the chosen source
  always_ff @(posedge clk) begin
    if (srst || mck_wr) begin
      prescaler_select_cnt_q <= 6'h00;
      master_clock_tick <= 1'b0;
    end else begin
      master_clock_tick <= src_pick && prescaler_select_end;
      if (src_pick) begin
        prescaler_select_cnt_q <= prescaler_select_end ? 6'h00 : prescaler_select_cnt_q + 6'h01;
      end
    end
  end

  // Ready once the first tick of the new setting has come out
  always_ff @(posedge clk) begin
    if (srst) begin
      master_clock_ready_q <= 1'b1;
    end else if (mck_wr) begin
      master_clock_ready_q <= 1'b0;
    end else if (master_clock_tick) begin
      master_clock_ready_q <= 1'b1;
    end
  end

  // ****************************************
  // Processor clock
  // ****************************************
  logic stop_req_q;          // Disable written, waiting for instruction end
  logic wake;

  assign wake = fast_int || norm_int;

  // Gate only at an instruction boundary; other masters run on master clock
  always_ff @(posedge clk) begin
    if (srst) begin
      processor_clock_en <= 1'b1;
      stop_req_q <= 1'b0;
    end else if (wake) begin
      processor_clock_en <= 1'b1;
      stop_req_q <= 1'b0;
    end else if (wr_hit(wr_pend_q, wr_addr_q, CKC_OFF_SCDR) && hwdata[0]) begin
      stop_req_q <= 1'b1;
    end else if (stop_req_q && instr_done) begin
      processor_clock_en <= 1'b0;
      stop_req_q <= 1'b0;
    end
  end

  // ****************************************
  // Status, mask and interrupt
  // ****************************************
  logic [CKC_ST_W-1:0] status;
  logic [CKC_ST_W-1:0] imask_q;

  assign status = {master_clock_ready_q, pll_locked_q[1], pll_locked_q[0], osc_stable_flag_q};

  // Mask register, all sources masked at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      imask_q <= '0;
    end else if (wr_hit(wr_pend_q, wr_addr_q, CKC_OFF_IMASK)) begin
      imask_q <= hwdata[CKC_ST_W-1:0];
    end
  end

  // Level interrupt follows the flags; no sticky copy
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & imask_q);
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      CKC_OFF_MAIN_OSC: begin
        rd_word[CKC_OSC_EN_BIT] = osc_enable;
        rd_word[CKC_OSC_BYP_BIT] = osc_bypass;
        rd_word[CKC_OSC_CNT_LSB +: CKC_OSC_CNT_W] = osc_cnt_q;
      end
      CKC_OFF_MAIN_FREQ: begin
        rd_word[CKC_FREQ_W-1:0] = main_freq_count_q;
        rd_word[CKC_FREQ_RDY_BIT] = freq_count_ready_q;
      end
      CKC_OFF_PLL_A, CKC_OFF_PLL_B: begin
        rd_word[CKC_DIV_LSB +: CKC_DIV_W] = pll_div_q[haddr[2]];
        rd_word[CKC_SETTLE_LSB +: CKC_SETTLE_W] = pll_settle_q[haddr[2]];
        rd_word[CKC_MUL_LSB +: CKC_MUL_W] = pll_mul_q[haddr[2]];
      end
      CKC_OFF_MCK: begin
        rd_word[CKC_CSS_LSB +: 2] = css_q;
        rd_word[CKC_PRESCALER_SELECT_LSB +: 3] = prescaler_select_q;
        rd_word[CKC_MASTER_DIVIDER_SELECT_LSB +: 2] = master_divider_select;
      end
      CKC_OFF_SCSR: begin
        rd_word[0] = processor_clock_en;
      end
      CKC_OFF_STATUS: begin
        rd_word[CKC_ST_W-1:0] = status;
      end
      CKC_OFF_IMASK: begin
        rd_word[CKC_ST_W-1:0] = imask_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured at the address phase, stands through the data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_word;
    end
  end

endmodule

// ---- verilog/ckc_pkg.sv ----
/*
 * Constants for the clock generator and master clock control block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ckc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CKC_OFF_MAIN_OSC = 8'h00;  // Oscillator control
  localparam logic [7:0] CKC_OFF_MAIN_FREQ = 8'h04; // Frequency measure, read only
  localparam logic [7:0] CKC_OFF_PLL_A = 8'h08;     // PLL A configuration
  localparam logic [7:0] CKC_OFF_PLL_B = 8'h0C;     // PLL B configuration
  localparam logic [7:0] CKC_OFF_MCK = 8'h10;       // Master clock selection
  localparam logic [7:0] CKC_OFF_SCDR = 8'h14;      // Processor clock disable, write only
  localparam logic [7:0] CKC_OFF_SCSR = 8'h18;      // Processor clock status
  localparam logic [7:0] CKC_OFF_STATUS = 8'h1C;    // Power status flags
  localparam logic [7:0] CKC_OFF_IMASK = 8'h20;     // Interrupt mask

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CKC_OSC_EN_BIT = 0;     // Oscillator enable
  localparam int CKC_OSC_BYP_BIT = 1;    // Oscillator bypass
  localparam int CKC_OSC_CNT_LSB = 8;    // Start-up count, 8 bits
  localparam int CKC_OSC_CNT_W = 8;
  localparam int CKC_FREQ_W = 16;        // Main frequency count width
  localparam int CKC_FREQ_RDY_BIT = 16;  // Frequency ready flag
  localparam int CKC_DIV_LSB = 0;        // PLL divider, 8 bits
  localparam int CKC_DIV_W = 8;
  localparam int CKC_SETTLE_LSB = 8;     // PLL settle count, 6 bits
  localparam int CKC_SETTLE_W = 6;
  localparam int CKC_MUL_LSB = 16;       // PLL multiplier, 11 bits
  localparam int CKC_MUL_W = 11;
  localparam int CKC_CSS_LSB = 0;        // Source select, 2 bits
  localparam int CKC_PRESCALER_SELECT_LSB = 2;       // Prescaler, 3 bits
  localparam int CKC_MASTER_DIVIDER_SELECT_LSB = 8;       // Master divider, 2 bits
  localparam int CKC_ST_OSC = 0;         // Status: oscillator stable
  localparam int CKC_ST_LOCK_A = 1;      // Status: PLL A locked
  localparam int CKC_ST_LOCK_B = 2;      // Status: PLL B locked
  localparam int CKC_ST_MCK = 3;         // Status: master clock ready
  localparam int CKC_ST_W = 4;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [1:0] CKC_CSS_SLOW = 2'h0;  // Slow clock selected at reset
  localparam logic [2:0] CKC_PRESCALER_SELECT_MAX = 3'h6;  // Division by 64
  localparam logic [2:0] CKC_SLOW_DIV = 3'h7;  // Slow clock divided by 8, count 0..7
  localparam logic [4:0] CKC_MEAS_PERIODS = 5'h10;  // Slow periods per measurement

  // Frequency measurement sequencer, one-hot
  typedef enum logic [3:0] {
    CKC_F_IDLE = 4'h1,
    CKC_F_WAIT = 4'h2,
    CKC_F_COUNT = 4'h4,
    CKC_F_DONE = 4'h8
  } ckc_freq_state_t;

endpackage

// ---- testbench/ckc_clock_ctrl_properties.sv ----
/* Assertions on the ports of the clock control block.
   Assumes one clock domain, clk, and the synchronous reset srst. */
`timescale 1ns/1ps
module ckc_props (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // Processor side
  input wire logic fast_int,
  input wire logic norm_int,
  input wire logic instr_done,
  // Controls driven by the block
  input wire logic osc_enable,
  input wire logic [ckc_pkg::CKC_DIV_W-1:0] pll_a_div,
  input wire logic [ckc_pkg::CKC_MUL_W-1:0] pll_a_mul,
  input wire logic pll_a_run,
  input wire logic [ckc_pkg::CKC_MUL_W-1:0] pll_b_mul,
  input wire logic pll_b_run,
  input wire logic master_clock_tick,
  input wire logic processor_clock_en
);
  import ckc_pkg::*;
  // ****************************************
  // Write decode and properties
  // ****************************************
  // Address phases of writes; data lands at the following edge
  wire wr_osc = hsel && htrans[1] && hwrite && haddr[7:0] == CKC_OFF_MAIN_OSC;
  wire wr_pa = hsel && htrans[1] && hwrite && haddr[7:0] == CKC_OFF_PLL_A;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst;
    $fell(srst) |-> !osc_enable && processor_clock_en && pll_a_div == 0 && !pll_a_run;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_osc_wr;
    wr_osc ##1 1'b1 |=> osc_enable == $past(hwdata[CKC_OSC_EN_BIT]);
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("enable bit not stored");
  property p_div_wr;
    wr_pa ##1 1'b1 |=> pll_a_div == $past(hwdata[CKC_DIV_W-1:0]);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divider not stored");
  property p_div_zero;
    pll_a_div == 0 && $past(pll_a_div) == 0 |-> !pll_a_run;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("runs with divider 0");
  property p_mul_zero;
    pll_b_mul == 0 && $past(pll_b_mul) == 0 |-> !pll_b_run;
  endproperty
  a_mul_zero: assert property (p_mul_zero) else $error("runs with mul 0");
  property p_run_on;
    $stable(pll_a_div) && $stable(pll_a_mul) && pll_a_div != 0 && pll_a_mul != 0 |-> pll_a_run;
  endproperty
  a_run_on: assert property (p_run_on) else $error("pll not running");
  // Gating waits for the instruction end, one or two cycles of pipeline
  property p_gate;
    $fell(processor_clock_en) |-> $past(instr_done) || $past(instr_done, 2);
  endproperty
  a_gate: assert property (p_gate) else $error("gated mid instruction");
  property p_wake;
    fast_int || norm_int |=> processor_clock_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");
  property p_no_self_wake;
    $rose(processor_clock_en) |-> $past(fast_int || norm_int);
  endproperty
  a_no_self_wake: assert property (p_no_self_wake) else $error("woke alone");
  c_osc_wr: cover property (wr_osc);
  c_gate: cover property ($fell(processor_clock_en));
  c_tick: cover property (master_clock_tick);
endmodule

bind ckc_clock_ctrl ckc_props u_props (.*);

// ---- testbench/ckc_osc_model.sv ----
/* Crystal or external clock model feeding the block's clock references.
   Assumes clk runs the whole time; all outputs are synchronous to it. */
`timescale 1ns/1ps
module ckc_osc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Oscillator controls from the block
  input wire logic osc_enable,
  input wire logic osc_bypass,
  // References towards the block
  output logic slow_clock,
  output logic main_clock,
  output logic [3:0] src_tick
);
  int slow_cnt = 0;  // Slow clock phase, 8 clk per period
  logic ptick = 1'b0;  // One pulse per main clock rise
  // Slow clock is the permanent clock, so it runs free
  always_ff @(posedge clk) begin
    slow_cnt <= (slow_cnt == 7) ? 0 : slow_cnt + 1;
  end
  assign slow_clock = (slow_cnt >= 4);
  // Main clock runs from the crystal or the external input, else stands low
  always_ff @(posedge clk) begin
    if (srst || !(osc_enable || osc_bypass)) begin
      main_clock <= 1'b0;
      ptick <= 1'b0;
    end else begin
      main_clock <= !main_clock;
      ptick <= !main_clock;
    end
  end
  // PLL sources are modelled as following the main clock
  assign src_tick = {ptick, ptick, ptick, 1'b0};
endmodule

// ---- testbench/tb_top.sv ----
/* Self-checking bench for the clock control block.
   Assumes an AHB-Lite single master and the oscillator model. */
`timescale 1ns/1ps
module tb_top;
  import ckc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, fast_int = 0, norm_int = 0, instr_done = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd_data, wd;
  logic [1:0] htrans = 0;
  logic [7:0] ra;
  logic rd_dp = 0;  // Data phase of a checked read
  logic [15:0] lfsr = 16'h3199;
  wire hreadyout, hresp, slow_clock, main_clock, osc_enable, osc_bypass, pll_a_run, pll_b_run;
  wire master_clock_tick, processor_clock_en, irq;
  wire [31:0] hrdata;
  wire [3:0] src_tick;
  wire [CKC_DIV_W-1:0] pll_a_div, pll_b_div;
  wire [CKC_MUL_W-1:0] pll_a_mul, pll_b_mul;
  wire [1:0] master_divider_select;
  logic [31:0] exp_q[$], msk_q[$];
  int fail_count = 0, checked = 0, cyc = 0, n, e;
  always #25 clk = !clk;
  ckc_clock_ctrl dut (.*, .hsize(3'h2), .hready(hreadyout));
  ckc_osc_model u_osc (.*);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic c);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr && c;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    rd_data = hrdata;
    rd_dp <= 1'b0;
  endtask
  // Checked read: the expectation is queued for the monitor
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0, 1'b1);
  endtask
  // Reads until a masked bit is set; k counts reads of two cycles each
  task automatic poll(input logic [7:0] a, input logic [31:0] m, output int k);
    k = 0;
    do begin
      bus(a, 1'b0, 32'h0, 1'b0);
      k++;
    end while (!(rd_data & m) && k < 400);
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Monitor takes the oldest note whenever read data stands
  always @(posedge clk) begin
    if (rd_dp && hreadyout) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(CKC_OFF_MAIN_OSC, 32'h0, ALL);
    rdc(CKC_OFF_MCK, 32'h0, ALL);
    rdc(CKC_OFF_PLL_B, 32'h0, ALL);
    rdc(CKC_OFF_SCSR, 32'h1, ALL);
    rdc(8'h3C, 32'h0, ALL);
    // Oscillator start-up with a count of 2, eight slow periods a step
    bus(CKC_OFF_MAIN_OSC, 1'b1, 32'h0201, 1'b0);
    rdc(CKC_OFF_STATUS, 32'h0, 32'h1);
    poll(CKC_OFF_STATUS, 32'h1, n);
    check(32'(n * 2 >= 60 && n * 2 <= 136), 32'h1);
    bus(CKC_OFF_IMASK, 1'b1, 32'h1, 1'b0);
    repeat (2) @(posedge clk);
    check(irq, 32'h1);
    bus(CKC_OFF_IMASK, 1'b1, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    check(irq, 32'h0);
    // Sixteen slow periods of 8 clk at a main period of 2 clk give 64
    poll(CKC_OFF_MAIN_FREQ, 32'h10000, n);
    check(32'(rd_data[15:0] >= 60 && rd_data[15:0] <= 66), 32'h1);
    bus(CKC_OFF_MAIN_OSC, 1'b1, 32'hFF01, 1'b0);
    rdc(CKC_OFF_MAIN_OSC, 32'hFF01, ALL);
    bus(CKC_OFF_MAIN_OSC, 1'b1, 32'h0, 1'b0);
    rdc(CKC_OFF_STATUS, 32'h0, 32'h1);
    bus(CKC_OFF_MAIN_OSC, 1'b1, 32'h2, 1'b0);
    @(posedge clk);
    check({osc_bypass, osc_enable}, 32'h2);
    // Both PLLs: random divider, settle count 6, then power down and zero divider
    for (int i = 0; i < 2; i++) begin
      ra = i ? CKC_OFF_PLL_B : CKC_OFF_PLL_A;
      wd = {16'h0003, 8'h06, 8'(rnd() % 16'hFF + 16'h1)};
      bus(ra, 1'b1, wd, 1'b0);
      rdc(CKC_OFF_STATUS, 32'h0, 32'h2 << i);
      check(i ? {pll_b_mul, pll_b_div} : {pll_a_mul, pll_a_div}, {wd[26:16], wd[7:0]});
      poll(CKC_OFF_STATUS, 32'h2 << i, n);
      check(32'(n * 2 >= 40 && n * 2 <= 64), 32'h1);
      bus(ra, 1'b1, wd & 32'hFFFF, 1'b0);
      rdc(CKC_OFF_STATUS, 32'h0, 32'h2 << i);
      check(i ? pll_b_run : pll_a_run, 32'h0);
      bus(ra, 1'b1, 32'h10000, 1'b0);
      repeat (3) @(posedge clk);
      check(i ? pll_b_run : pll_a_run, 32'h0);
      bus(ra, 1'b1, 32'h100FF, 1'b0);
      rdc(ra, 32'h100FF, 32'h7FF00FF);
    end
    // Every source, then every prescaler on the main clock
    for (int k = 0; k < 11; k++) begin
      bus(CKC_OFF_MCK, 1'b1, 32'h200 | (k < 4 ? k : 32'h1 | ((k - 3) << 2)), 1'b0);
      if (k >= 6) rdc(CKC_OFF_STATUS, 32'h0, 32'h8);
      poll(CKC_OFF_STATUS, 32'h8, n);
      e = (k == 0 ? 8 : 2) << (k < 4 ? 0 : (k > 9 ? 6 : k - 3));
      do @(negedge clk); while (!master_clock_tick);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!master_clock_tick && n < 200);
      check(n, e);
      @(posedge clk);
    end
    check(master_divider_select, 32'h2);
    // Idle gating: waits for instruction end, wakes on either interrupt
    for (int w = 0; w < 2; w++) begin
      bus(CKC_OFF_SCDR, 1'b1, 32'h1, 1'b0);
      repeat (4) @(posedge clk);
      check(processor_clock_en, 32'h1);
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      repeat (3) @(posedge clk);
      check(processor_clock_en, 32'h0);
      rdc(CKC_OFF_SCSR, 32'h0, ALL);
      if (w) fast_int <= 1'b1;
      else norm_int <= 1'b1;
      @(posedge clk);
      fast_int <= 1'b0;
      norm_int <= 1'b0;
      repeat (2) @(posedge clk);
      check(processor_clock_en, 32'h1);
    end
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule
